// [gdp_pkg.sv]
// constants and types for the gear-down and power-save mode controller
// assumes: command pins decoded into a 3-bit code on the link clock
package gdp_pkg;
   typedef enum logic [2:0] {
      GDP_DES = 3'h0,
      GDP_NOP = 3'h1,
      GDP_MRS = 3'h2,
      GDP_REF = 3'h3,
      GDP_SRE = 3'h4,
      GDP_SRX = 3'h5,
      GDP_OTH = 3'h6
   } gdp_cmd_t;

   // gray order along 1N -> armed -> settle -> 2N
   typedef enum logic [1:0] {
      GD_1N     = 2'h0,
      GD_ARMED  = 2'h1,
      GD_SETTLE = 2'h3,
      GD_2N     = 2'h2
   } gdp_gear_t;

   // gray order along run -> enter -> hibernate -> exit
   typedef enum logic [1:0] {
      MP_RUN   = 2'h0,
      MP_ENTER = 2'h1,
      MP_HIB   = 2'h3,
      MP_EXIT  = 2'h2
   } gdp_mpsm_t;

   localparam int         GDP_MRD_W    = 8;
   localparam logic [2:0] GDP_GEAR_MR  = 3'h3;
   localparam int         GDP_GEAR_BIT = 3;
   localparam logic [2:0] GDP_MPSM_MR  = 3'h4;
   localparam int         GDP_MPSM_BIT = 1;

   localparam int GDP_LCNT_W = 10;
   localparam int GDP_MCNT_W = 12;
   typedef logic [GDP_LCNT_W-1:0] gdp_lcnt_t;
   typedef logic [GDP_MCNT_W-1:0] gdp_mcnt_t;

   // link-side intervals in link clocks
   localparam int GDP_T_CMD_GEAR_CK = 24;
   localparam int GDP_T_DLLK_CK     = 768;

   // power-save intervals, converted to system clocks (rounded up)
   localparam int GDP_CLK_NS        = 40;
   localparam int GDP_T_MPED_NS     = 200;
   localparam int GDP_T_XMP_NS      = 400;
   localparam int GDP_T_XMP_DLL_NS  = 24000;
   localparam int GDP_MPED_CYC =
      (GDP_T_MPED_NS + GDP_CLK_NS - 1) / GDP_CLK_NS;
   localparam int GDP_XMP_CYC =
      (GDP_T_XMP_NS + GDP_CLK_NS - 1) / GDP_CLK_NS;
   localparam int GDP_XMP_DLL_CYC =
      (GDP_T_XMP_DLL_NS + GDP_CLK_NS - 1) / GDP_CLK_NS;
endpackage

// [gdp_mode_ctrl.sv]
// command-interface clock mode and maximum power-save control
// assumes: cmd, mr_sel, mr_data, cal_en, par_en are synchronous to ck;
// cs_n and cke also reach the clk domain, where exit from hibernate is
// seen while ck may be stopped

// How it works
// - after reset the command interface runs in 1N clocking
// - gear-down entry only at init or self refresh exit
// - slow gear-down MRS arms; next CS pulse with NOP syncs edge
// - 2N takes effect on the clock after the sync pulse
// - self refresh entry returns the interface to 1N
// - commands allowed after command-gear; DLL ones after DLL lock
// - in power-save, commands ignored and stored data lost
// - power-save entered by mode-register command
// - after entry delay all inputs but CKE, CS, reset ignored
// - CKE rise with CS high keeps device in power-save
// - CKE rise with CS low clears power-save and starts exit
// - exit interval gates commands, DLL ones wait longer
module gdp_mode_ctrl
   import gdp_pkg::*;
#(
   parameter int CMD_GEAR = GDP_T_CMD_GEAR_CK,
   parameter int DLLK     = GDP_T_DLLK_CK
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 ck,
   input  wire logic                 cs_n,
   input  wire logic                 cke,
   input  wire logic [2:0]           cmd,
   input  wire logic [2:0]           mr_sel,
   input  wire logic [GDP_MRD_W-1:0] mr_data,
   input  wire logic                 cal_en,
   input  wire logic                 par_en,
   output logic                      cmd_valid,
   output logic                      gear_2n,
   output logic                      gear_phase,
   output logic                      gear_cmd_ok,
   output logic                      gear_dll_ok,
   output logic                      sync_odd_err,
   output logic                      mpsm_active,
   output logic                      mpsm_cmd_ok,
   output logic                      mpsm_dll_ok,
   output logic                      data_lost
);

   if (CMD_GEAR < 1 || CMD_GEAR >= (1 << GDP_LCNT_W) ||
       DLLK < 1 || DLLK >= (1 << GDP_LCNT_W)) begin
      $error("gdp_mode_ctrl: interval outside counter range");
   end

   // link-domain reset and power-save level crossings
   logic lrst_q1, lrst_q2, mb_q1, mb_q2;

   always_ff @(posedge ck) begin
      lrst_q1 <= rst_n;
      lrst_q2 <= lrst_q1;
      mb_q1   <= mpsm_active;
      mb_q2   <= mb_q1;
   end

   // in 2N only the aligned edge carries a command
   logic take;
   assign take = !cs_n && cke && !mb_q2 && (!gear_2n || !gear_phase);
   logic gear_req, mpsm_req;
   assign gear_req = cmd == GDP_MRS && mr_sel == GDP_GEAR_MR &&
                     mr_data[GDP_GEAR_BIT];
   assign mpsm_req = cmd == GDP_MRS && mr_sel == GDP_MPSM_MR &&
                     mr_data[GDP_MPSM_BIT];

   always_ff @(posedge ck) begin
      if (!lrst_q2) begin
         cmd_valid <= 1'b0;
      end else begin
         cmd_valid <= take;
      end
   end

   // gear-down sequencing
   gdp_gear_t gst;
   gdp_lcnt_t gcnt, dcnt;
   logic      win;

   always_ff @(posedge ck) begin
      if (!lrst_q2) begin
         win <= 1'b1;
      end else if (take && cmd == GDP_SRX) begin
         win <= 1'b1;
      end else if (take && cmd != GDP_REF && cmd != GDP_NOP) begin
         win <= 1'b0;
      end
   end

   always_ff @(posedge ck) begin
      if (!lrst_q2) begin
         gst          <= GD_1N;
         gcnt         <= '0;
         gear_2n      <= 1'b0;
         gear_phase   <= 1'b0;
         gear_cmd_ok  <= 1'b1;
         sync_odd_err <= 1'b0;
      end else begin
         gear_phase <= gear_2n && !gear_phase;
         if (take && cmd == GDP_SRE) begin
            gst         <= GD_1N;
            gear_2n     <= 1'b0;
            gear_phase  <= 1'b0;
            gear_cmd_ok <= 1'b1;
         end else begin
            case (gst)
               GD_1N: begin
                  if (take && gear_req && win && !cal_en && !par_en) begin
                     gst         <= GD_ARMED;
                     gcnt        <= '0;
                     gear_cmd_ok <= 1'b0;
                  end
               end
               GD_ARMED: begin
                  gcnt <= gcnt + 1'b1;
                  if (take && cmd == GDP_NOP) begin
                     gst          <= GD_SETTLE;
                     sync_odd_err <= !gcnt[0];
                     gcnt         <= '0;
                     gear_2n      <= 1'b1;
                     gear_phase   <= 1'b1;
                  end
               end
               GD_SETTLE: begin
                  gcnt <= gcnt + 1'b1;
                  if (gcnt == gdp_lcnt_t'(CMD_GEAR - 1)) begin
                     gst         <= GD_2N;
                     gear_cmd_ok <= 1'b1;
                  end
               end
               GD_2N: begin
                  gst <= GD_2N;
               end
               default: begin
                  gst <= GD_1N;
               end
            endcase
         end
      end
   end

   // DLL-dependent commands wait a full lock interval from the sync
   always_ff @(posedge ck) begin
      if (!lrst_q2) begin
         dcnt        <= '0;
         gear_dll_ok <= 1'b1;
      end else if (gst == GD_ARMED && take && cmd == GDP_NOP) begin
         dcnt        <= '0;
         gear_dll_ok <= 1'b0;
      end else if (!gear_dll_ok) begin
         dcnt <= dcnt + 1'b1;
         if (dcnt == gdp_lcnt_t'(DLLK - 1)) begin
            gear_dll_ok <= 1'b1;
         end
      end
   end

   // entry is refused while gear-down is on, so exit timing stays safe
   logic ent_tgl;
   always_ff @(posedge ck) begin
      if (!lrst_q2) begin
         ent_tgl <= 1'b0;
      end else if (take && mpsm_req && gst == GD_1N) begin
         ent_tgl <= !ent_tgl;
      end
   end

   // system-domain crossings: entry toggle, cke and cs_n levels
   logic et_q1, et_q2, et_q3;
   logic cke_q1, cke_q2, cke_q3;
   logic csn_q1, csn_q2;

   always_ff @(posedge clk) begin
      et_q1  <= ent_tgl;
      et_q2  <= et_q1;
      et_q3  <= et_q2;
      cke_q1 <= cke;
      cke_q2 <= cke_q1;
      cke_q3 <= cke_q2;
      csn_q1 <= cs_n;
      csn_q2 <= csn_q1;
   end

   logic ent_evt, cke_rise;
   assign ent_evt  = et_q2 ^ et_q3;
   assign cke_rise = cke_q2 && !cke_q3;
   gdp_mpsm_t mst, next_mst;
   gdp_mcnt_t mcnt, xcnt;

   always_comb begin
      next_mst = mst;
      case (mst)
         MP_RUN: begin
            if (ent_evt) begin
               next_mst = MP_ENTER;
            end
         end
         MP_ENTER: begin
            if (mcnt == gdp_mcnt_t'(GDP_MPED_CYC - 1)) begin
               next_mst = MP_HIB;
            end
         end
         MP_HIB: begin
            if (cke_rise && !csn_q2) begin
               next_mst = MP_EXIT;
            end
         end
         MP_EXIT: begin
            if (xcnt == gdp_mcnt_t'(GDP_XMP_CYC - 1)) begin
               next_mst = MP_RUN;
            end
         end
         default: begin
            next_mst = MP_RUN;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mst         <= MP_RUN;
         mpsm_active <= 1'b0;
         mpsm_cmd_ok <= 1'b1;
         mcnt        <= '0;
      end else begin
         mst         <= next_mst;
         mpsm_active <= next_mst != MP_RUN;
         mpsm_cmd_ok <= next_mst == MP_RUN;
         mcnt        <= (mst == MP_ENTER) ? mcnt + 1'b1 : '0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         xcnt        <= '0;
         mpsm_dll_ok <= 1'b1;
      end else if (mst == MP_RUN && ent_evt) begin
         xcnt        <= '0;
         mpsm_dll_ok <= 1'b0;
      end else if (mst == MP_EXIT || (mst == MP_RUN && !mpsm_dll_ok)) begin
         xcnt <= xcnt + 1'b1;
         if (xcnt == gdp_mcnt_t'(GDP_XMP_DLL_CYC - 1)) begin
            mpsm_dll_ok <= 1'b1;
         end
      end
   end

   // contents are gone once hibernate is reached; only reset clears it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         data_lost <= 1'b0;
      end else if (next_mst == MP_HIB) begin
         data_lost <= 1'b1;
      end
   end

   property p_reset_1n;
      @(posedge ck) !lrst_q2 |=> !gear_2n && gst == GD_1N;
   endproperty
   a_reset_1n: assert property (p_reset_1n)
      else $error("not in 1N after reset");
   property p_sre_1n;
      @(posedge ck) disable iff (!lrst_q2)
         take && cmd == GDP_SRE |=> !gear_2n && gst == GD_1N;
   endproperty
   a_sre_1n: assert property (p_sre_1n)
      else $error("self refresh entry kept 2N");
   property p_rise_from_sync;
      @(posedge ck) disable iff (!lrst_q2)
         $rose(gear_2n) |-> $past(gst) == GD_ARMED;
   endproperty
   a_rise_from_sync: assert property (p_rise_from_sync)
      else $error("2N entered without armed sequence");
   property p_arm_window;
      @(posedge ck) disable iff (!lrst_q2)
         $rose(gst == GD_ARMED) |-> $past(win);
   endproperty
   a_arm_window: assert property (p_arm_window)
      else $error("gear-down armed outside entry window");
   property p_sync_parity;
      @(posedge ck) disable iff (!lrst_q2)
         gst == GD_ARMED && take && cmd == GDP_NOP
         |=> gst == GD_SETTLE && sync_odd_err == !$past(gcnt[0]);
   endproperty
   a_sync_parity: assert property (p_sync_parity)
      else $error("sync pulse parity flag wrong");
   property p_no_entry_cal;
      @(posedge ck) disable iff (!lrst_q2)
         gst == GD_1N && (cal_en || par_en) |=> gst == GD_1N;
   endproperty
   a_no_entry_cal: assert property (p_no_entry_cal)
      else $error("gear-down armed with CAL or parity on");
   property p_cmd_gear;
      @(posedge ck) disable iff (!lrst_q2)
         gst == GD_SETTLE |-> !gear_cmd_ok && gcnt < gdp_lcnt_t'(CMD_GEAR);
   endproperty
   a_cmd_gear: assert property (p_cmd_gear)
      else $error("commands allowed before command-gear expired");
   property p_ignore_hib;
      @(posedge ck) disable iff (!lrst_q2) mb_q2 |=> !cmd_valid;
   endproperty
   a_ignore_hib: assert property (p_ignore_hib)
      else $error("command taken in power-save");
   property p_stay_hib;
      @(posedge clk) disable iff (!rst_n)
         mst == MP_HIB && cke_rise && csn_q2 |=> mst == MP_HIB;
   endproperty
   a_stay_hib: assert property (p_stay_hib)
      else $error("left power-save with CS high");
   property p_exit_hib;
      @(posedge clk) disable iff (!rst_n)
         mst == MP_HIB && cke_rise && !csn_q2
         |=> mst == MP_EXIT ##[1:300] mpsm_cmd_ok;
   endproperty
   a_exit_hib: assert property (p_exit_hib)
      else $error("power-save exit not completed");
   property p_enter_lost;
      @(posedge clk) disable iff (!rst_n)
         mst == MP_RUN && ent_evt |=> mpsm_active ##[1:8] data_lost;
   endproperty
   a_enter_lost: assert property (p_enter_lost)
      else $error("hibernate not reached after entry delay");

endmodule

// [gdp_host_model.sv]
// controller-side model: link clock, chip select, clock enable, commands
// assumes: the device samples all of these on rising edges of ck
module gdp_host_model
   import gdp_pkg::*;
(
   input  wire logic                 gear_phase,
   output logic                      ck = 1'b0,
   output logic                      cs_n = 1'b1,
   output logic                      cke = 1'b1,
   output logic [2:0]                cmd = GDP_DES,
   output logic [2:0]                mr_sel = 3'h0,
   output logic [GDP_MRD_W-1:0]      mr_data = '0,
   output logic                      cal_en = 1'b0,
   output logic                      par_en = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;
   bit ck_run = 1'b1;

   // stopped clock rests low, never mid-pulse
   initial forever #16 ck = ck_run ? ~ck : 1'b0;

   // slow static command: lines set a cycle ahead, one-cycle select
   task automatic issue(input gdp_cmd_t c, input logic [2:0] s,
                        input logic [7:0] d);
      @(posedge ck);
      #2;
      cmd = c;
      mr_sel = s;
      mr_data = d;
      @(posedge ck);
      #2;
      // bounded: a stuck phase lets the command through to be refused
      for (int k = 0; k < 4 && gear_phase === 1'b1; k++) begin
         @(posedge ck);
         #2;
      end
      cs_n = 1'b0;
      @(posedge ck);
      #2;
      cs_n = 1'b1;
      @(posedge ck);
      #2;
      // deselected lines must not keep showing the last command
      cmd = ~cmd;
      mr_sel = ~mr_sel;
      mr_data = ~mr_data;
   endtask
endmodule

// [gdp_mode_ctrl_test.sv]
// self-checking bench for the gear-down and power-save controller
// assumes: gdp_host_model stands in for the memory controller
module gdp_mode_ctrl_test
   import gdp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ck, cs_n, cke, cal_en, par_en;
   logic [2:0] cmd, mr_sel;
   logic [7:0] mr_data;
   logic cmd_valid, gear_2n, gear_phase, gear_cmd_ok, gear_dll_ok;
   logic sync_odd_err, mpsm_active, mpsm_cmd_ok, mpsm_dll_ok, data_lost;
   int err_total = 0;
   int n_checks = 0;
   int n_valid = 0;
   int nv;

   initial forever #20 clk = ~clk;

   gdp_host_model i_gdp_host_model (.gear_phase(gear_phase), .ck(ck),
      .cs_n(cs_n), .cke(cke), .cmd(cmd), .mr_sel(mr_sel),
      .mr_data(mr_data), .cal_en(cal_en), .par_en(par_en));

   // short intervals keep the run brief
   gdp_mode_ctrl #(.CMD_GEAR(4), .DLLK(16)) i_gdp_mode_ctrl (.clk(clk),
      .rst_n(rst_n), .ck(ck), .cs_n(cs_n), .cke(cke), .cmd(cmd),
      .mr_sel(mr_sel), .mr_data(mr_data), .cal_en(cal_en),
      .par_en(par_en), .cmd_valid(cmd_valid), .gear_2n(gear_2n),
      .gear_phase(gear_phase), .gear_cmd_ok(gear_cmd_ok),
      .gear_dll_ok(gear_dll_ok), .sync_odd_err(sync_odd_err),
      .mpsm_active(mpsm_active), .mpsm_cmd_ok(mpsm_cmd_ok),
      .mpsm_dll_ok(mpsm_dll_ok), .data_lost(data_lost));

   always @(posedge ck) if (cmd_valid === 1'b1) n_valid++;

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask

   function automatic logic sig(input int s);
      case (s)
         0: return gear_cmd_ok;
         1: return gear_dll_ok;
         2: return mpsm_active;
         3: return data_lost;
         default: return mpsm_dll_ok;
      endcase
   endfunction

   task automatic wait_lvl(input int s, input logic v, input int lim);
      int i;
      for (i = 0; i < lim && sig(s) !== v; i++) begin
         @(posedge clk);
         #2;
      end
      if (i == lim) begin
         $display("Error at %0t: wait on %0d ran out", $time, s);
         err_total++;
         tally_and_finish();
      end
   endtask

   task automatic gear_mrs();
      // a fast speed grade is assumed; no latency field is rewritten in 2N
      i_gdp_host_model.issue(GDP_MRS, GDP_GEAR_MR, 8'h08);
   endtask

   task automatic s_sr();
      i_gdp_host_model.issue(GDP_SRE, 3'h0, 8'h00);
      chk(gear_2n, 1'b0);
      chk(gear_phase, 1'b0);
      i_gdp_host_model.issue(GDP_SRX, 3'h0, 8'h00);
   endtask

   task automatic s_refused(input logic cal, input logic par, input bit oth);
      i_gdp_host_model.cal_en = cal;
      i_gdp_host_model.par_en = par;
      if (oth) i_gdp_host_model.issue(GDP_OTH, 3'h0, 8'h00);
      nv = n_valid;
      gear_mrs();
      repeat (8) @(posedge ck);
      #2;
      chk(n_valid - nv, 1);
      chk(gear_cmd_ok, 1'b1);
      chk(gear_2n, 1'b0);
      i_gdp_host_model.cal_en = 1'b0;
      i_gdp_host_model.par_en = 1'b0;
      s_sr();
   endtask

   task automatic s_gear(input int idle, input logic odd);
      nv = n_valid;
      i_gdp_host_model.issue(GDP_REF, 3'h0, 8'h00);
      gear_mrs();
      chk(gear_cmd_ok, 1'b0);
      repeat (idle) @(posedge ck);
      i_gdp_host_model.issue(GDP_NOP, 3'h0, 8'h00);
      chk(gear_2n, 1'b1);
      chk(sync_odd_err, odd);
      chk(gear_cmd_ok, 1'b0);
      chk(gear_dll_ok, 1'b0);
      chk(n_valid - nv, 3);
      chk(gear_phase, 1'b0);
      @(posedge ck);
      #2;
      chk(gear_phase, 1'b1);
      wait_lvl(0, 1'b1, 8);
      wait_lvl(1, 1'b1, 40);
   endtask

   task automatic s_power();
      i_gdp_host_model.issue(GDP_MRS, GDP_MPSM_MR, 8'h02);
      repeat (12) @(posedge clk);
      #2;
      chk(mpsm_active, 1'b0);
      s_sr();
      i_gdp_host_model.issue(GDP_MRS, GDP_MPSM_MR, 8'h02);
      wait_lvl(2, 1'b1, 8);
      chk(mpsm_cmd_ok, 1'b0);
      chk(data_lost, 1'b0);
      wait_lvl(3, 1'b1, 8);
      nv = n_valid;
      i_gdp_host_model.issue(GDP_REF, 3'h0, 8'h00);
      chk(n_valid - nv, 0);
      i_gdp_host_model.ck_run = 1'b0;
      i_gdp_host_model.cke = 1'b0;
      repeat (4) @(posedge clk);
      #2;
      i_gdp_host_model.cke = 1'b1;
      repeat (20) @(posedge clk);
      #2;
      chk(mpsm_active, 1'b1);
      i_gdp_host_model.cke = 1'b0;
      i_gdp_host_model.cs_n = 1'b0;
      repeat (4) @(posedge clk);
      #2;
      i_gdp_host_model.cke = 1'b1;
      repeat (4) @(posedge clk);
      #2;
      i_gdp_host_model.cs_n = 1'b1;
      i_gdp_host_model.ck_run = 1'b1;
      wait_lvl(2, 1'b0, 20);
      chk(mpsm_cmd_ok, 1'b1);
      chk(mpsm_dll_ok, 1'b0);
      chk(data_lost, 1'b1);
      wait_lvl(4, 1'b1, 700);
   endtask

   initial begin
      repeat (16) @(posedge clk);
      #2;
      rst_n = 1'b1;
      repeat (4) @(posedge clk);
      #2;
      chk(gear_2n, 1'b0);
      chk(mpsm_active, 1'b0);
      s_refused(1'b1, 1'b0, 1'b0);
      s_refused(1'b0, 1'b1, 1'b0);
      s_refused(1'b0, 1'b0, 1'b1);
      s_gear(1, 1'b1);
      s_sr();
      s_gear(0, 1'b0);
      s_power();
      tally_and_finish();
   end
endmodule
